//--- hdl/fscp_pkg.sv
`default_nettype none
package fscp_pkg;
    localparam int BYTE_W = 8;
    localparam int HDR_BYTES = 8;
    localparam int HDR_BITS = HDR_BYTES * BYTE_W;
    localparam logic [3:0] HDR_LEN = 4'h8;
    localparam logic [3:0] HDR_LAST_IDX = 4'h7;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;

    localparam logic [15:0] CLUSTER_ID = 16'h0023;
    localparam logic [7:0] STORE_ENDPOINT = 8'hE6;

    localparam int OFS_CMD = 0;
    localparam int OFS_OPTION = 1;
    localparam int OFS_STATUS = 1;
    localparam int OFS_BLOCK = 2;
    localparam int OFS_OFFSET = 4;
    localparam int OFS_LENGTH = 6;

    localparam logic [7:0] CMD_GEOMETRY_QUERY = 8'h00;
    localparam logic [7:0] CMD_GEOMETRY_REPLY = 8'h80;
    localparam int STATUS_ERR_BIT = 0;
    localparam logic [7:0] STATUS_OK = 8'h00;
    localparam logic [7:0] STATUS_ERR = 8'h01;
    localparam logic [15:0] BLOCK_COUNT = 16'h0077;
    localparam logic [15:0] BLOCK_SIZE = 16'h0200;
    localparam logic [15:0] LEN_NONE = 16'h0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [63:0] HDR_ZERO = 64'h0000000000000000;

    // Byte 0 of a header sits in the top byte
    function automatic logic [7:0] fscp_byte(input logic [63:0] hdr, input int ofs);
        fscp_byte = hdr[HDR_BITS - 1 - BYTE_W * ofs -: BYTE_W];
    endfunction

    // Two-byte field, most significant byte first
    function automatic logic [15:0] fscp_get16(input logic [63:0] hdr, input int ofs);
        fscp_get16 = hdr[HDR_BITS - 1 - BYTE_W * ofs -: 2 * BYTE_W];
    endfunction
endpackage
`default_nettype wire

//--- hdl/fscp_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface fscp_link_if;
    logic rq_valid;
    logic [7:0] rq_data;
    logic rq_last;
    logic rq_bcast;
    logic [15:0] rq_cluster;
    logic [7:0] rq_dst_ep;
    logic [7:0] rq_src_ep;
    logic rs_valid;
    logic [7:0] rs_data;
    logic rs_last;
    logic [7:0] rs_dst_ep;

    modport device (
        input rq_valid, rq_data, rq_last, rq_bcast, rq_cluster, rq_dst_ep, rq_src_ep,
        output rs_valid, rs_data, rs_last, rs_dst_ep
    );
    modport requester (
        output rq_valid, rq_data, rq_last, rq_bcast, rq_cluster, rq_dst_ep, rq_src_ep,
        input rs_valid, rs_data, rs_last, rs_dst_ep
    );
endinterface
`default_nettype wire

//--- hdl/fscp_device.sv
`timescale 1ns/100ps
`default_nettype none
module fscp_device (
    input wire logic mclk_in,
    input wire logic nrst_in,
    fscp_link_if.device link,
    output logic exec_out,
    output logic [7:0] exec_cmd_out,
    output logic exec_err_out,
    output logic exec_bcast_out,
    output logic busy_out
);
    typedef enum logic [1:0] {
        FSCP_DEV_IDLE = 2'b01,
        FSCP_DEV_SEND = 2'b10
    } fscp_dev_state_t;

    // Reply header: code, status, block, offset, length
    function automatic logic [63:0] fscp_reply(input logic [63:0] hdr);
        logic [7:0] cmd;
        logic [7:0] code;
        logic [7:0] status;
        logic [15:0] blk;
        logic [15:0] ofs;
        logic [15:0] len;
        cmd = fscp_pkg::fscp_byte(hdr, fscp_pkg::OFS_CMD);
        len = fscp_pkg::LEN_NONE;
        if (cmd == fscp_pkg::CMD_GEOMETRY_QUERY) begin
            code = fscp_pkg::CMD_GEOMETRY_REPLY;
            status = fscp_pkg::STATUS_OK;
            blk = fscp_pkg::BLOCK_COUNT;
            ofs = fscp_pkg::BLOCK_SIZE;
        end else begin
            // Unrecognised code: echo it with the error bit
            code = cmd;
            status = fscp_pkg::STATUS_ERR;
            blk = fscp_pkg::fscp_get16(hdr, fscp_pkg::OFS_BLOCK);
            ofs = fscp_pkg::fscp_get16(hdr, fscp_pkg::OFS_OFFSET);
        end
        fscp_reply = {code, status, blk, ofs, len};
    endfunction

    // Frame is for the store and long enough to hold a header
    function automatic logic fscp_accept(input logic [15:0] cluster, input logic [7:0] ep,
        input logic [3:0] cnt);
        fscp_accept = (cluster == fscp_pkg::CLUSTER_ID)
            && (ep == fscp_pkg::STORE_ENDPOINT)
            && (cnt >= fscp_pkg::HDR_LAST_IDX);
    endfunction

    // Error flag as carried in the status byte of a reply
    function automatic logic fscp_reply_err(input logic [63:0] rsp);
        logic [7:0] status;
        status = fscp_pkg::fscp_byte(rsp, fscp_pkg::OFS_STATUS);
        fscp_reply_err = status[fscp_pkg::STATUS_ERR_BIT];
    endfunction

    fscp_dev_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [63:0] hdr_q, hdr_d;
    logic [63:0] tx_q, tx_d;
    logic [3:0] txcnt_q, txcnt_d;
    logic rs_valid_q, rs_valid_d;
    logic [7:0] rs_data_q, rs_data_d;
    logic rs_last_q, rs_last_d;
    logic [7:0] rs_dst_q, rs_dst_d;
    logic exec_q, exec_d;
    logic [7:0] cmd_q, cmd_d;
    logic err_q, err_d;
    logic bcast_q, bcast_d;
    logic busy_q, busy_d;

    // Frame receive, reply shift-out and execute report
    always_comb begin
        logic [63:0] full_hdr;
        logic [63:0] reply;
        logic hit;
        full_hdr = hdr_q;
        reply = fscp_pkg::HDR_ZERO;
        hit = 1'b0;
        state_d = state_q;
        cnt_d = cnt_q;
        hdr_d = hdr_q;
        tx_d = tx_q;
        txcnt_d = txcnt_q;
        rs_valid_d = 1'b0;
        rs_data_d = rs_data_q;
        rs_last_d = 1'b0;
        rs_dst_d = rs_dst_q;
        exec_d = 1'b0;
        cmd_d = cmd_q;
        err_d = err_q;
        bcast_d = bcast_q;
        case (state_q)
            FSCP_DEV_IDLE: begin
                if (link.rq_valid) begin
                    // Bytes past the header are neither counted nor stored
                    if (cnt_q != fscp_pkg::HDR_LEN) begin
                        full_hdr = {hdr_q[fscp_pkg::HDR_BITS-fscp_pkg::BYTE_W-1:0],
                            link.rq_data};
                        hdr_d = full_hdr;
                        cnt_d = cnt_q + fscp_pkg::CNT_ONE;
                    end
                    if (link.rq_last) begin
                        cnt_d = fscp_pkg::CNT_ZERO;
                        hit = fscp_accept(link.rq_cluster, link.rq_dst_ep, cnt_q);
                        if (hit) begin
                            reply = fscp_reply(full_hdr);
                            exec_d = 1'b1;
                            cmd_d = fscp_pkg::fscp_byte(full_hdr, fscp_pkg::OFS_CMD);
                            err_d = fscp_reply_err(reply);
                            bcast_d = link.rq_bcast;
                            if (!link.rq_bcast) begin
                                tx_d = reply;
                                txcnt_d = fscp_pkg::CNT_ZERO;
                                rs_dst_d = link.rq_src_ep;
                                state_d = FSCP_DEV_SEND;
                            end
                        end
                    end
                end
            end
            FSCP_DEV_SEND: begin
                // Requests arriving while the reply goes out are dropped
                rs_valid_d = 1'b1;
                rs_data_d = fscp_pkg::fscp_byte(tx_q, fscp_pkg::OFS_CMD);
                tx_d = {tx_q[fscp_pkg::HDR_BITS-fscp_pkg::BYTE_W-1:0], fscp_pkg::BYTE_ZERO};
                txcnt_d = txcnt_q + fscp_pkg::CNT_ONE;
                cnt_d = fscp_pkg::CNT_ZERO;
                if (txcnt_q == fscp_pkg::HDR_LAST_IDX) begin
                    rs_last_d = 1'b1;
                    state_d = FSCP_DEV_IDLE;
                end
            end
            default: begin
                state_d = FSCP_DEV_IDLE;
                cnt_d = fscp_pkg::CNT_ZERO;
            end
        endcase
        busy_d = (state_d == FSCP_DEV_SEND);
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= FSCP_DEV_IDLE;
            cnt_q <= fscp_pkg::CNT_ZERO;
            hdr_q <= fscp_pkg::HDR_ZERO;
            tx_q <= fscp_pkg::HDR_ZERO;
            txcnt_q <= fscp_pkg::CNT_ZERO;
            rs_valid_q <= 1'b0;
            rs_data_q <= fscp_pkg::BYTE_ZERO;
            rs_last_q <= 1'b0;
            rs_dst_q <= fscp_pkg::BYTE_ZERO;
            exec_q <= 1'b0;
            cmd_q <= fscp_pkg::BYTE_ZERO;
            err_q <= 1'b0;
            bcast_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            hdr_q <= hdr_d;
            tx_q <= tx_d;
            txcnt_q <= txcnt_d;
            rs_valid_q <= rs_valid_d;
            rs_data_q <= rs_data_d;
            rs_last_q <= rs_last_d;
            rs_dst_q <= rs_dst_d;
            exec_q <= exec_d;
            cmd_q <= cmd_d;
            err_q <= err_d;
            bcast_q <= bcast_d;
            busy_q <= busy_d;
        end
    end

    // Ports come straight from the registers
    assign link.rs_valid = rs_valid_q;
    assign link.rs_data = rs_data_q;
    assign link.rs_last = rs_last_q;
    assign link.rs_dst_ep = rs_dst_q;
    assign exec_out = exec_q;
    assign exec_cmd_out = cmd_q;
    assign exec_err_out = err_q;
    assign exec_bcast_out = bcast_q;
    assign busy_out = busy_q;
endmodule
`default_nettype wire

//--- hdl/fscp_requester.sv
`timescale 1ns/100ps
`default_nettype none
module fscp_requester (
    input wire logic mclk_in,
    input wire logic nrst_in,
    fscp_link_if.requester link,
    input wire logic start_in,
    input wire logic [7:0] cmd_in,
    input wire logic [7:0] option_in,
    input wire logic [15:0] block_in,
    input wire logic [15:0] offset_in,
    input wire logic [15:0] length_in,
    input wire logic bcast_in,
    input wire logic [7:0] src_ep_in,
    input wire logic explicit_mode_in,
    output logic busy_out,
    output logic rsp_valid_out,
    output logic [7:0] rsp_cmd_out,
    output logic [7:0] rsp_status_out,
    output logic [15:0] rsp_block_out,
    output logic [15:0] rsp_offset_out,
    output logic [15:0] rsp_length_out,
    output logic rsp_explicit_out
);
    typedef enum logic [2:0] {
        FSCP_REQ_IDLE = 3'b001,
        FSCP_REQ_SEND = 3'b010,
        FSCP_REQ_WAIT = 3'b100
    } fscp_req_state_t;

    fscp_req_state_t state_q, state_d;
    logic [63:0] tx_q, tx_d;
    logic [3:0] cnt_q, cnt_d;
    logic [63:0] rx_q, rx_d;
    logic rq_valid_q, rq_valid_d;
    logic [7:0] rq_data_q, rq_data_d;
    logic rq_last_q, rq_last_d;
    logic bcast_q, bcast_d;
    logic [7:0] src_q, src_d;
    logic expl_q, expl_d;
    logic rsp_valid_q, rsp_valid_d;
    logic [63:0] rsp_q, rsp_d;
    logic rsp_expl_q, rsp_expl_d;
    logic busy_q, busy_d;

    always_comb begin
        logic [63:0] full_rx;
        full_rx = rx_q;
        state_d = state_q;
        tx_d = tx_q;
        cnt_d = cnt_q;
        rx_d = rx_q;
        rq_valid_d = 1'b0;
        rq_data_d = rq_data_q;
        rq_last_d = 1'b0;
        bcast_d = bcast_q;
        src_d = src_q;
        expl_d = expl_q;
        rsp_valid_d = 1'b0;
        rsp_d = rsp_q;
        rsp_expl_d = rsp_expl_q;
        case (state_q)
            FSCP_REQ_IDLE: begin
                if (start_in) begin
                    // Only the header goes out; no data bytes
                    tx_d = {cmd_in, option_in, block_in, offset_in, length_in};
                    bcast_d = bcast_in;
                    src_d = src_ep_in;
                    expl_d = (src_ep_in == fscp_pkg::STORE_ENDPOINT) || explicit_mode_in;
                    cnt_d = fscp_pkg::CNT_ZERO;
                    state_d = FSCP_REQ_SEND;
                end
            end
            FSCP_REQ_SEND: begin
                rq_valid_d = 1'b1;
                rq_data_d = fscp_pkg::fscp_byte(tx_q, fscp_pkg::OFS_CMD);
                tx_d = {tx_q[fscp_pkg::HDR_BITS-fscp_pkg::BYTE_W-1:0], fscp_pkg::BYTE_ZERO};
                cnt_d = cnt_q + fscp_pkg::CNT_ONE;
                if (cnt_q == fscp_pkg::HDR_LAST_IDX) begin
                    rq_last_d = 1'b1;
                    cnt_d = fscp_pkg::CNT_ZERO;
                    state_d = bcast_q ? FSCP_REQ_IDLE : FSCP_REQ_WAIT;
                end
            end
            FSCP_REQ_WAIT: begin
                if (link.rs_valid && (link.rs_dst_ep == src_q)) begin
                    if (cnt_q != fscp_pkg::HDR_LEN) begin
                        full_rx = {rx_q[fscp_pkg::HDR_BITS-fscp_pkg::BYTE_W-1:0],
                            link.rs_data};
                        rx_d = full_rx;
                        cnt_d = cnt_q + fscp_pkg::CNT_ONE;
                    end
                    if (link.rs_last) begin
                        rsp_valid_d = 1'b1;
                        rsp_d = full_rx;
                        rsp_expl_d = expl_q;
                        cnt_d = fscp_pkg::CNT_ZERO;
                        state_d = FSCP_REQ_IDLE;
                    end
                end
            end
            default: begin
                state_d = FSCP_REQ_IDLE;
                cnt_d = fscp_pkg::CNT_ZERO;
            end
        endcase
        busy_d = (state_d != FSCP_REQ_IDLE);
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= FSCP_REQ_IDLE;
            tx_q <= fscp_pkg::HDR_ZERO;
            cnt_q <= fscp_pkg::CNT_ZERO;
            rx_q <= fscp_pkg::HDR_ZERO;
            rq_valid_q <= 1'b0;
            rq_data_q <= fscp_pkg::BYTE_ZERO;
            rq_last_q <= 1'b0;
            bcast_q <= 1'b0;
            src_q <= fscp_pkg::BYTE_ZERO;
            expl_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_q <= fscp_pkg::HDR_ZERO;
            rsp_expl_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            tx_q <= tx_d;
            cnt_q <= cnt_d;
            rx_q <= rx_d;
            rq_valid_q <= rq_valid_d;
            rq_data_q <= rq_data_d;
            rq_last_q <= rq_last_d;
            bcast_q <= bcast_d;
            src_q <= src_d;
            expl_q <= expl_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_q <= rsp_d;
            rsp_expl_q <= rsp_expl_d;
            busy_q <= busy_d;
        end
    end

    assign link.rq_valid = rq_valid_q;
    assign link.rq_data = rq_data_q;
    assign link.rq_last = rq_last_q;
    assign link.rq_bcast = bcast_q;
    assign link.rq_cluster = fscp_pkg::CLUSTER_ID;
    assign link.rq_dst_ep = fscp_pkg::STORE_ENDPOINT;
    assign link.rq_src_ep = src_q;
    assign busy_out = busy_q;
    assign rsp_valid_out = rsp_valid_q;
    assign rsp_cmd_out = fscp_pkg::fscp_byte(rsp_q, fscp_pkg::OFS_CMD);
    assign rsp_status_out = fscp_pkg::fscp_byte(rsp_q, fscp_pkg::OFS_STATUS);
    assign rsp_block_out = fscp_pkg::fscp_get16(rsp_q, fscp_pkg::OFS_BLOCK);
    assign rsp_offset_out = fscp_pkg::fscp_get16(rsp_q, fscp_pkg::OFS_OFFSET);
    assign rsp_length_out = fscp_pkg::fscp_get16(rsp_q, fscp_pkg::OFS_LENGTH);
    assign rsp_explicit_out = rsp_expl_q;
endmodule
`default_nettype wire

//--- verification/fscp_chk.sv
`timescale 1ns/100ps
`default_nettype none
module fscp_chk (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic rq_valid,
    input wire logic [7:0] rq_data,
    input wire logic rq_last,
    input wire logic rq_bcast,
    input wire logic [15:0] rq_cluster,
    input wire logic [7:0] rq_dst_ep,
    input wire logic [7:0] rq_src_ep,
    input wire logic rs_valid,
    input wire logic [7:0] rs_data,
    input wire logic rs_last,
    input wire logic [7:0] rs_dst_ep
);
    logic [3:0] qn_q, qn_d, sn_q, sn_d;
    logic [7:0] cmd_q, cmd_d, src_q, src_d;
    // Request byte index, reply byte index, captured command and source
    always_comb begin
        qn_d = qn_q;
        sn_d = sn_q;
        cmd_d = cmd_q;
        src_d = src_q;
        if (rq_valid) begin
            qn_d = rq_last ? 4'h0 : qn_q + 4'h1;
            if (qn_q == 4'h0)
                cmd_d = rq_data;
            if (rq_last)
                src_d = rq_src_ep;
        end
        if (rs_valid)
            sn_d = rs_last ? 4'h0 : sn_q + 4'h1;
    end
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            qn_q <= 4'h0;
            sn_q <= 4'h0;
            cmd_q <= 8'h00;
            src_q <= 8'h00;
        end else begin
            qn_q <= qn_d;
            sn_q <= sn_d;
            cmd_q <= cmd_d;
            src_q <= src_d;
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_start;
        $rose(rs_valid);
    endsequence
    sequence s_geo;
        rs_data == 8'h00 ##1 rs_data == 8'h00 ##1 rs_data == 8'h77 ##1 rs_data == 8'h02
            ##1 rs_data == 8'h00 ##1 rs_data == 8'h00 ##1 rs_data == 8'h00;
    endsequence
    addr_fixed_a: assert property (rq_valid |-> rq_cluster == 16'h0023 && rq_dst_ep == 8'hE6)
        else $error("request not aimed at store");
    reply_start_a: assert property (rq_valid && rq_last && !rq_bcast |-> ##2 s_start)
        else $error("no reply to unicast");
    bcast_quiet_a: assert property (rq_valid && rq_last && rq_bcast |=> !rs_valid [*8])
        else $error("reply to broadcast");
    reply_len_a: assert property (s_start |-> rs_valid [*8] ##1 !rs_valid)
        else $error("reply not eight bytes");
    last_pos_a: assert property (s_start |-> !rs_last [*7] ##1 rs_last)
        else $error("reply last misplaced");
    cmd_echo_a: assert property (s_start |-> rs_data == (cmd_q == 8'h00 ? 8'h80 : cmd_q))
        else $error("reply code wrong");
    dst_ep_a: assert property (s_start |-> rs_dst_ep == src_q)
        else $error("reply endpoint wrong");
    status_bits_a: assert property (rs_valid && sn_q == 4'h1 |-> rs_data == {7'h00, cmd_q != 8'h00})
        else $error("status byte wrong");
    len_zero_a: assert property (rs_valid && sn_q > 4'h5 |-> rs_data == 8'h00)
        else $error("reply length not zero");
    geo_fields_a: assert property (s_start and rs_data == 8'h80 |=> s_geo)
        else $error("geometry fields wrong");
endmodule
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) check_val((g), (e))
module tb_top;
    logic mclk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic start_in = 1'b0;
    logic [7:0] cmd_in = 8'h00;
    logic [15:0] block_in = 16'h0000;
    logic [15:0] offset_in = 16'h0000;
    logic [15:0] length_in = 16'h0000;
    logic bcast_in = 1'b0;
    logic [7:0] src_ep_in = 8'h00;
    logic expl_in = 1'b0;
    logic busy, rv, rx, ex, eer, ebc, ex2;
    logic [7:0] rc, rst, ecm;
    logic [15:0] rb, ro, rl;
    int fail_count = 0;
    int checks_done = 0;
    logic [7:0] rqb [8];
    logic [7:0] rsb [8];
    logic [7:0] ecmd, rdst, b2, d2;
    logic eerr, ebcs;
    int rqn, rsn, nex, n2, x2, nbz;
    logic dbusy;
    fscp_link_if link();
    fscp_link_if link2();
    always #5 mclk_in = ~mclk_in;
    fscp_requester fscp_requester_i (.mclk_in(mclk_in), .nrst_in(nrst_in), .link(link),
        .start_in(start_in), .cmd_in(cmd_in), .option_in(8'h00), .block_in(block_in),
        .offset_in(offset_in), .length_in(length_in), .bcast_in(bcast_in),
        .src_ep_in(src_ep_in), .explicit_mode_in(expl_in), .busy_out(busy),
        .rsp_valid_out(rv), .rsp_cmd_out(rc), .rsp_status_out(rst), .rsp_block_out(rb),
        .rsp_offset_out(ro), .rsp_length_out(rl), .rsp_explicit_out(rx));
    fscp_device fscp_device_i (.mclk_in(mclk_in), .nrst_in(nrst_in), .link(link),
        .exec_out(ex), .exec_cmd_out(ecm), .exec_err_out(eer), .exec_bcast_out(ebc),
        .busy_out(dbusy));
    fscp_device fscp_device_i2 (.mclk_in(mclk_in), .nrst_in(nrst_in), .link(link2),
        .exec_out(ex2), .exec_cmd_out(), .exec_err_out(), .exec_bcast_out(), .busy_out());
    fscp_chk fscp_chk_i (.mclk_in(mclk_in), .nrst_in(nrst_in), .rq_valid(link.rq_valid),
        .rq_data(link.rq_data), .rq_last(link.rq_last), .rq_bcast(link.rq_bcast),
        .rq_cluster(link.rq_cluster), .rq_dst_ep(link.rq_dst_ep), .rq_src_ep(link.rq_src_ep),
        .rs_valid(link.rs_valid), .rs_data(link.rs_data), .rs_last(link.rs_last),
        .rs_dst_ep(link.rs_dst_ep));
    task automatic check_val(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("Error at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // One request through the requester, recording both directions of the wire
    task automatic run_req(input logic [7:0] c, input logic [15:0] b, input logic [15:0] o,
        input logic [15:0] l, input logic bc, input logic [7:0] s, input logic x);
        bit done;
        done = 0;
        rqn = 0;
        rsn = 0;
        nex = 0;
        nbz = 0;
        @(posedge mclk_in);
        start_in <= 1'b1;
        cmd_in <= c;
        block_in <= b;
        offset_in <= o;
        length_in <= l;
        bcast_in <= bc;
        src_ep_in <= s;
        expl_in <= x;
        @(posedge mclk_in);
        start_in <= 1'b0;
        for (int i = 0; i < 40 && !done; i++) begin
            @(negedge mclk_in);
            if (link.rq_valid && rqn < 8)
                rqb[rqn++] = link.rq_data;
            if (link.rs_valid) begin
                rsb[rsn[2:0]] = link.rs_data;
                rdst = link.rs_dst_ep;
                rsn++;
            end
            if (dbusy === 1'b1)
                nbz++;
            if (ex === 1'b1) begin
                nex++;
                ecmd = ecm;
                eerr = eer;
                ebcs = ebc;
            end
            done = (rv === 1'b1) || (bc && nex > 0 && busy === 1'b0);
        end
        if (!done) begin
            fail_count++;
            $display("Error at %0t: no answer", $time);
            wrap_up();
        end
        repeat (10) begin
            @(negedge mclk_in);
            if (link.rs_valid !== 1'b0)
                rsn++;
        end
    endtask
    task automatic t_geometry();
        logic [63:0] g;
        g = {8'h80, 8'h00, 16'h0077, 16'h0200, 16'h0000};
        run_req(8'h00, 16'h0000, 16'h0000, 16'h0000, 1'b0, 8'hE6, 1'b0);
        `CHK(rqn, 8);
        for (int i = 0; i < 8; i++) begin
            `CHK(rqb[i], 8'h00);
            `CHK(rsb[i], g[63 - 8 * i -: 8]);
        end
        `CHK(rsn, 8);
        `CHK(rdst, 8'hE6);
        `CHK(nbz, 8);
        `CHK({rc, rst}, 16'h8000);
        `CHK({rb, ro}, 32'h00770200);
        `CHK(rl, 16'h0000);
        `CHK(rx, 1'b1);
        `CHK({nex[1:0], ecmd, eerr, ebcs}, 12'h400);
        $display("test geometry done");
    endtask
    task automatic t_unknown();
        logic [7:0] codes [4] = '{8'h01, 8'h02, 8'h03, 8'h5A};
        logic [63:0] q, e;
        for (int k = 0; k < 4; k++) begin
            q = {codes[k], 8'h00, 16'h1234, 16'hABCD, 16'h0005};
            e = {codes[k], 8'h01, 16'h1234, 16'hABCD, 16'h0000};
            run_req(codes[k], 16'h1234, 16'hABCD, 16'h0005, 1'b0, 8'h21, k == 3);
            for (int i = 0; i < 8; i++) begin
                `CHK(rqb[i], q[63 - 8 * i -: 8]);
                `CHK(rsb[i], e[63 - 8 * i -: 8]);
            end
            `CHK({rst, rl}, 24'h010000);
            `CHK(rx, k == 3);
            `CHK({ecmd, eerr}, {codes[k], 1'b1});
            `CHK(rdst, 8'h21);
        end
        $display("test unknown codes done");
    endtask
    task automatic t_bcast();
        run_req(8'h00, 16'h0000, 16'h0000, 16'h0000, 1'b1, 8'hE6, 1'b0);
        `CHK(rsn, 0);
        `CHK(nbz, 0);
        `CHK({nex[1:0], ebcs}, 3'h3);
        $display("test broadcast done");
    endtask
    // Raw frame on the second link, then watch the second device
    task automatic send2(input logic [15:0] cl, input logic [7:0] dp, input int n,
        input logic [7:0] s);
        n2 = 0;
        x2 = 0;
        for (int i = 0; i < n; i++) begin
            @(posedge mclk_in);
            link2.rq_valid <= 1'b1;
            link2.rq_data <= (i < 8) ? 8'h00 : 8'hA5;
            link2.rq_last <= (i == n - 1);
            link2.rq_cluster <= cl;
            link2.rq_dst_ep <= dp;
            link2.rq_src_ep <= s;
        end
        @(posedge mclk_in);
        link2.rq_valid <= 1'b0;
        link2.rq_last <= 1'b0;
        link2.rq_data <= 8'hFF;
        repeat (20) begin
            @(negedge mclk_in);
            if (link2.rs_valid !== 1'b0) begin
                if (n2 == 0)
                    b2 = link2.rs_data;
                d2 = link2.rs_dst_ep;
                n2++;
            end
            if (ex2 !== 1'b0)
                x2++;
        end
    endtask
    task automatic t_faults();
        send2(16'h0024, 8'hE6, 8, 8'h10);
        `CHK(n2 + x2, 0);
        send2(16'h0023, 8'hE7, 8, 8'h10);
        `CHK(n2 + x2, 0);
        send2(16'h0023, 8'hE6, 5, 8'h10);
        `CHK(n2 + x2, 0);
        send2(16'h0023, 8'hE6, 11, 8'h45);
        `CHK({n2[7:0], b2, d2}, 24'h088045);
        $display("test link faults done");
    endtask
    initial begin
        link2.rq_valid = 1'b0;
        link2.rq_data = 8'h00;
        link2.rq_last = 1'b0;
        link2.rq_bcast = 1'b0;
        link2.rq_cluster = 16'h0023;
        link2.rq_dst_ep = 8'hE6;
        link2.rq_src_ep = 8'h00;
        repeat (3) @(posedge mclk_in);
        nrst_in <= 1'b1;
        t_geometry();
        t_unknown();
        t_bcast();
        t_geometry();
        t_faults();
        wrap_up();
    end
endmodule
`default_nettype wire
